//--- core/whf_core.sv
// Wake-up handshake and fault reaction controller of an H-bridge driver.
// Summary of operation
// (R1) Controller raises wake request to leave sleep.
// (R2) After wake or reset, pull fault pin low.
// (R3) Controller acknowledges wake with fault-clear command.
// (R4) On acknowledgment release pin, enter standby.
// (R5) Internal-supply variant: hold reset during regulator undervoltage.
// (R6) External-supply variant: reset follows logic supply.
// (R7) Controller acknowledges power-up with fault-clear command.
// (R8) Filtered overcurrent disables output, pulls pin low.
// (R9) Retry mode re-enables after delay, repeats.
// (R10) Thermal retry waits for cool-down, not delay.
// (R11) Clean retry keeps output; pin released after clear.
// (R12) Serial variants latch fault status until clear.
// (R13) High-side short holds sense output at clamp.
// (R14) Latch mode waits for clear or sleep pulse.
// (R15) External-supply variant has no wake request pin.
// (R16) Retry delay nominally 5 ms.
// (R17) Overcurrent clear time at least 85 us.
// (R18) Thermal clear time at least 4.2 ms.
// (R19) Hardwired controller acknowledges with sleep-pin reset pulse.
// (R20) Clear under persistent fault retrips after filter.
// (R21) Timers run from oscillator, restart on new fault.
`timescale 1ns/10ps
`include "whf_defines.svh"
module whf_core #(
	parameter int RETRY_US = `WHF_RETRY_US,
	parameter int CLEAR_TSD_US = `WHF_CLEAR_TSD_US,
	parameter int CLEAR_US = `WHF_CLEAR_US,
	parameter int OCP_FILT_US = `WHF_OCP_FILT_US,
	parameter int INIT_TICKS = `WHF_INIT_TICKS
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic supply_good,
	input wire whf_pkg::whf_cfg_t cfg,
	input wire logic wake_request_pin,
	input wire logic fault_clear_command,
	input wire logic drive_enable,
	input wire whf_pkg::whf_sense_t sense,
	output logic fault_indicator_pin_o,
	output logic fault_indicator_pin_oe_n,
	output logic output_enable,
	output logic sense_clamp_active,
	output logic fault_status,
	output logic device_standby
);

	// Timers hold 16 bits of 1 us ticks.
	if (RETRY_US < 1 || RETRY_US > 65535 || CLEAR_TSD_US < 1 || CLEAR_TSD_US > 65535 ||
		CLEAR_US < 1 || CLEAR_US > 65535 || OCP_FILT_US < 1 || INIT_TICKS < 1) begin : g_chk
		$error("whf_core: timing parameter out of range");
	end

	// ==================================================================
	// Reset qualification and tick source
	// ==================================================================
	logic por_n; // Power-on reset release, low while the supply in use is low.
	logic wake_eff;
	logic tick;

	// The supply input is the regulator level on the internal-supply part and
	// the logic supply on the external one; both hold the logic in reset.
	assign por_n = rstn & supply_good; // see (R5) see (R6)
	// With an external supply there is no wake pin: it reads as always high.
	assign wake_eff = cfg.ext_supply ? 1'b1 : wake_request_pin; // see (R15)

	whf_tick #(.DIV(`WHF_TICK_CYC)) u_tick (
		.clk_sys(clk_sys),
		.rstn(por_n),
		.tick(tick)
	);

	// ==================================================================
	// State and timers
	// ==================================================================
	whf_pkg::whf_state_t st_q;
	whf_pkg::whf_state_t st_d;
	logic wake_q;
	logic pulse_ack;
	logic ack;
	logic tsd_q;
	logic tsd_d;
	logic fstat_d;
	logic ocp_filt_done;
	logic retry_done;
	logic clr_done;
	logic init_done;
	logic retry_run;
	logic clr_run;
	logic [15:0] retry_lim;
	logic [15:0] clr_lim;

	// A wake-pin low-then-high pulse acknowledges on the hardwired part.
	assign pulse_ack = !cfg.serial_variant && wake_eff && !wake_q; // see (R19)
	assign ack = cfg.serial_variant ? fault_clear_command : pulse_ack; // see (R3) see (R7)

	// Overcurrent must persist for the filter time before it is confirmed.
	whf_timer #(.W(16)) u_filt (
		.clk_sys(clk_sys), .rstn(por_n), .tick(tick),
		.restart(!sense.overcurrent_shutdown), .run(sense.overcurrent_shutdown && output_enable),
		.limit(16'(OCP_FILT_US)), .done(ocp_filt_done)
	);

	// The thermal restart waits for the cool-down instead of the fixed delay.
	assign retry_lim = tsd_q ? 16'(CLEAR_TSD_US) : 16'(RETRY_US); // see (R10) see (R16) see (R18)
	assign retry_run = (st_q == whf_pkg::WHF_FAULT_OFF) && cfg.retry_mode && !sense.thermal_shutdown_event;
	whf_timer #(.W(16)) u_retry (
		.clk_sys(clk_sys), .rstn(por_n), .tick(tick),
		.restart(sense.thermal_shutdown_event), .run(retry_run), // see (R21)
		.limit(retry_lim), .done(retry_done)
	);

	// Fault-free time after a clean retry; any fault restarts it.
	assign clr_lim = 16'(CLEAR_US); // see (R17)
	assign clr_run = (st_q == whf_pkg::WHF_RETRY_ON);
	whf_timer #(.W(16)) u_clr (
		.clk_sys(clk_sys), .rstn(por_n), .tick(tick),
		.restart(sense.overcurrent_shutdown || sense.thermal_shutdown_event), .run(clr_run), // see (R21)
		.limit(clr_lim), .done(clr_done)
	);

	whf_timer #(.W(16)) u_init (
		.clk_sys(clk_sys), .rstn(por_n), .tick(tick),
		.restart(wake_eff && !wake_q), .run(st_q == whf_pkg::WHF_INIT),
		.limit(16'(INIT_TICKS)), .done(init_done)
	);

	// ==================================================================
	// Next-state logic
	// ==================================================================
	logic pin_low_d;
	logic oen_d;
	logic clamp_d;
	logic confirm;

	assign confirm = (ocp_filt_done && sense.overcurrent_shutdown) || sense.thermal_shutdown_event; // see (R8)

	// One process settles the state, the pin, the output and the status.
	always_comb
	begin
		st_d = st_q;
		tsd_d = tsd_q;
		fstat_d = fault_status;
		pin_low_d = !fault_indicator_pin_oe_n;
		oen_d = output_enable;
		clamp_d = sense_clamp_active;
		case (st_q)
			whf_pkg::WHF_SLEEP:
			begin
				pin_low_d = 1'b0;
				oen_d = 1'b0;
				if (wake_eff)
				begin
					st_d = whf_pkg::WHF_INIT; // see (R1)
					pin_low_d = 1'b1; // see (R2)
				end
			end
			whf_pkg::WHF_INIT:
			begin
				if (init_done)
					st_d = whf_pkg::WHF_WAIT_ACK;
			end
			whf_pkg::WHF_WAIT_ACK:
			begin
				if (ack)
				begin
					st_d = whf_pkg::WHF_STANDBY; // see (R4)
					pin_low_d = 1'b0;
				end
			end
			whf_pkg::WHF_STANDBY:
			begin
				oen_d = drive_enable;
				if (output_enable && confirm)
				begin
					st_d = whf_pkg::WHF_FAULT_OFF; // see (R8)
					oen_d = 1'b0;
					pin_low_d = 1'b1;
					fstat_d = 1'b1;
					tsd_d = sense.thermal_shutdown_event;
					clamp_d = sense.ocp_hs_gnd && !sense.thermal_shutdown_event; // see (R13)
				end
				else if (cfg.serial_variant && fault_status && fault_clear_command)
					fstat_d = 1'b0; // see (R12)
			end
			whf_pkg::WHF_FAULT_OFF:
			begin
				oen_d = 1'b0;
				if (cfg.retry_mode && retry_done && drive_enable)
				begin
					st_d = whf_pkg::WHF_RETRY_ON; // see (R9)
					oen_d = 1'b1;
					clamp_d = 1'b0;
				end
				else if (!cfg.retry_mode && ack)
				begin
					// Detection restarts at once, so a persisting fault retrips.
					st_d = whf_pkg::WHF_STANDBY; // see (R14) see (R20)
					oen_d = drive_enable;
					pin_low_d = 1'b0;
					clamp_d = 1'b0;
					fstat_d = 1'b0;
				end
			end
			whf_pkg::WHF_RETRY_ON:
			begin
				oen_d = 1'b1;
				if (confirm)
				begin
					st_d = whf_pkg::WHF_FAULT_OFF; // see (R9)
					oen_d = 1'b0;
					tsd_d = sense.thermal_shutdown_event;
					clamp_d = sense.ocp_hs_gnd && !sense.thermal_shutdown_event; // see (R13)
				end
				else if (clr_done)
				begin
					st_d = whf_pkg::WHF_STANDBY; // see (R11)
					pin_low_d = 1'b0;
					fstat_d = cfg.serial_variant; // see (R12)
				end
			end
			default:
				st_d = whf_pkg::WHF_SLEEP;
		endcase
		// Sleep request on internal-supply parts in retry mode or serial drops the state, the output and the pin.
		if (!wake_eff && st_q != whf_pkg::WHF_SLEEP && cfg.retry_mode | cfg.serial_variant)
		begin
			st_d = whf_pkg::WHF_SLEEP;
			oen_d = 1'b0;
			pin_low_d = 1'b0;
		end
	end

	// Power-on reset wakes straight into initialisation with the pin low.
	always_ff @(posedge clk_sys or negedge por_n)
	begin
		if (!por_n)
		begin
			st_q <= whf_pkg::WHF_INIT; // see (R2)
			wake_q <= 1'b1;
			tsd_q <= 1'b0;
			fault_status <= 1'b0;
			fault_indicator_pin_oe_n <= 1'b0;
			fault_indicator_pin_o <= 1'b0;
			output_enable <= 1'b0;
			sense_clamp_active <= 1'b0;
			device_standby <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			wake_q <= wake_eff;
			tsd_q <= tsd_d;
			fault_status <= fstat_d;
			fault_indicator_pin_oe_n <= !pin_low_d;
			fault_indicator_pin_o <= 1'b0;
			output_enable <= oen_d;
			sense_clamp_active <= clamp_d;
			device_standby <= (st_d == whf_pkg::WHF_STANDBY);
		end
	end

	// ==================================================================
	// Checks
	// ==================================================================
	a_fault_disables: assert property (@(posedge clk_sys) disable iff (!por_n) // see (R8)
		(st_q == whf_pkg::WHF_FAULT_OFF) |-> !output_enable)
		else $error("output enabled while fault off");
	a_fault_pin_low: assert property (@(posedge clk_sys) disable iff (!por_n) // see (R8)
		(st_q == whf_pkg::WHF_FAULT_OFF && $past(st_q) != whf_pkg::WHF_FAULT_OFF
		&& $past(st_q) == whf_pkg::WHF_STANDBY) |-> !fault_indicator_pin_oe_n)
		else $error("fault pin not low on fault");
	a_ack_standby: assert property (@(posedge clk_sys) disable iff (!por_n) // see (R4)
		(st_q == whf_pkg::WHF_WAIT_ACK && ack && wake_eff) |=> device_standby
		&& fault_indicator_pin_oe_n)
		else $error("ack did not reach standby");
	a_wait_pin_low: assert property (@(posedge clk_sys) disable iff (!por_n) // see (R2)
		(st_q == whf_pkg::WHF_WAIT_ACK) |-> !fault_indicator_pin_oe_n)
		else $error("pin released before ack");
	a_clamp_off: assert property (@(posedge clk_sys) disable iff (!por_n) // see (R13)
		sense_clamp_active |-> !output_enable)
		else $error("clamp while output on");
	a_latch_hold: assert property (@(posedge clk_sys) disable iff (!por_n) // see (R14)
		(st_q == whf_pkg::WHF_FAULT_OFF && !cfg.retry_mode && !ack && wake_eff)
		|=> st_q == whf_pkg::WHF_FAULT_OFF)
		else $error("latched fault left without clear");
	a_ext_no_sleep: assert property (@(posedge clk_sys) disable iff (!por_n) // see (R15)
		cfg.ext_supply |-> st_q != whf_pkg::WHF_SLEEP)
		else $error("sleep without wake pin");
	a_retry_on_out: assert property (@(posedge clk_sys) disable iff (!por_n) // see (R11)
		(st_q == whf_pkg::WHF_RETRY_ON) |-> output_enable && !fault_indicator_pin_oe_n)
		else $error("retry state wrong outputs");

endmodule

//--- core/whf_defines.svh
// Timing constants for the wake handshake and fault reaction block.
`ifndef WHF_DEFINES_SVH
`define WHF_DEFINES_SVH

// Clock rate in kHz (40 MHz).
`define WHF_CLK_KHZ 40000
// Oscillator tick period in ns; timers count ticks of 1 us.
`define WHF_TICK_NS 1000
`define WHF_TICK_CYC ((`WHF_TICK_NS * `WHF_CLK_KHZ) / 1000000)
// Retry delay, nominal, in us.
`define WHF_RETRY_US 5000
// Fault-free time before an overcurrent clears, least value, in us.
`define WHF_CLEAR_US 85
// Fault-free time before a thermal fault clears, least value, in us.
`define WHF_CLEAR_TSD_US 4200
// Overcurrent filter time in us (not printed here; plain default).
`define WHF_OCP_FILT_US 4
// Initialisation time after wake-up, in ticks.
`define WHF_INIT_TICKS 16

`endif

//--- core/whf_pkg.sv
// Types shared by the wake handshake and fault reaction block.
package whf_pkg;

	// Main operating states of the device controller.
	typedef enum logic [2:0] {
		WHF_SLEEP,
		WHF_INIT,
		WHF_WAIT_ACK,
		WHF_STANDBY,
		WHF_FAULT_OFF,
		WHF_RETRY_ON
	} whf_state_t;

	// Fault sensing inputs grouped together.
	typedef struct packed {
		logic overcurrent_shutdown;
		logic ocp_hs_gnd;
		logic thermal_shutdown_event;
	} whf_sense_t;

	// Device strap options.
	typedef struct packed {
		logic retry_mode;
		logic serial_variant;
		logic ext_supply;
	} whf_cfg_t;

endpackage

//--- core/whf_tick.sv
// Internal oscillator tick divider producing a one-cycle enable pulse.
`timescale 1ns/10ps
module whf_tick #(
	parameter int DIV = 40
) (
	input wire logic clk_sys,
	input wire logic rstn,
	output logic tick
);

	// Reject a divider that cannot produce a pulse.
	if (DIV < 1) begin : g_chk
		$error("whf_tick: DIV must be at least 1");
	end

	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic tick_d;

	// Count down, pulse when the count reaches zero, then reload DIV-1.
	always_comb
	begin
		tick_d = (cnt_q == 16'h0000);
		cnt_d = tick_d ? 16'(DIV - 1) : cnt_q - 16'h0001;
	end

	// Register the count and the pulse.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_q <= 16'h0000;
			tick <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			tick <= tick_d;
		end
	end

endmodule

//--- core/whf_timer.sv
// Restartable tick timer that flags when a programmed interval has elapsed.
`timescale 1ns/10ps
module whf_timer #(
	parameter int W = 16
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic tick,
	input wire logic restart,
	input wire logic run,
	input wire logic [W-1:0] limit,
	output logic done
);

	if (W < 2) begin : g_chk
		$error("whf_timer: W must be at least 2");
	end

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic done_d;

	// Restart wins over counting, so a new fault always times a fresh interval.
	always_comb
	begin
		cnt_d = cnt_q;
		done_d = done;
		if (restart || !run)
		begin
			cnt_d = '0;
			done_d = 1'b0;
		end
		else if (tick && !done)
		begin
			cnt_d = cnt_q + 1'b1;
			done_d = (cnt_d >= limit);
		end
	end

	// Register the count and the elapsed flag.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_q <= '0;
			done <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			done <= done_d;
		end
	end

endmodule

//--- verif/wake_handshake_fault_reaction_bench.sv
// Self-checking bench for the wake handshake and fault reaction controller.
`timescale 1ns/10ps
module wake_handshake_fault_reaction_bench;
	localparam int TK = 40;
	localparam int RT = 20;
	localparam int CT = 20;
	localparam int CL = 5;
	localparam int FL = 2;
	localparam int IN = 2;
	logic clk_sys, rstn, supply_good, drive_enable;
	logic wake_request_pin, fault_clear_command, pin_o, pin_oe_n, pin_level;
	logic output_enable, sense_clamp_active, fault_status, device_standby;
	whf_pkg::whf_cfg_t cfg;
	whf_pkg::whf_sense_t sense;
	int miscompares, checks_done, cycles, n;

	// Timer parameters are cut down so the run stays short.
	whf_core #(.RETRY_US(RT), .CLEAR_TSD_US(CT), .CLEAR_US(CL), .OCP_FILT_US(FL),
		.INIT_TICKS(IN)) DUT (.clk_sys(clk_sys), .rstn(rstn), .supply_good(supply_good),
		.cfg(cfg), .wake_request_pin(wake_request_pin),
		.fault_clear_command(fault_clear_command), .drive_enable(drive_enable),
		.sense(sense), .fault_indicator_pin_o(pin_o), .fault_indicator_pin_oe_n(pin_oe_n),
		.output_enable(output_enable), .sense_clamp_active(sense_clamp_active),
		.fault_status(fault_status), .device_standby(device_standby));

	whf_ctrl_model ctrl (.clk_sys(clk_sys), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
		.wake_request_pin(wake_request_pin), .fault_clear_command(fault_clear_command),
		.pin_level(pin_level));

	// Free-running 40 MHz clock.
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// A hung wait would stall forever, so the run is cut at a cycle ceiling.
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// Count cycles until output enable (0) or line level (1) equals v.
	task automatic wait_sig(input int which, input logic v, input int lim);
		n = 0;
		@(negedge clk_sys);
		while (((which == 0) ? output_enable : pin_level) !== v && n < lim)
		begin
			@(negedge clk_sys);
			n++;
		end
	endtask

	task automatic in_range(input string what, input int lo, input int hi);
		check(what, 32'(n >= lo && n <= hi), 32'h0000_0001);
	endtask

	task automatic handshake();
		repeat ((IN + 1) * TK) @(posedge clk_sys);
		if (cfg.serial_variant)
			ctrl.send_clear(1'b1);
		else
			ctrl.pulse_wake();
		repeat (3) @(negedge clk_sys);
		check("line released", pin_level, 1'b1);
		check("standby", device_standby, 1'b1);
	endtask

	task automatic restart(input logic retry, input logic serial);
		@(posedge clk_sys);
		#2 rstn = 1'b0;
		cfg.retry_mode = retry;
		cfg.serial_variant = serial;
		repeat (20) @(posedge clk_sys);
		#2 rstn = 1'b1;
		@(negedge clk_sys);
		check("line low after reset", pin_level, 1'b0);
		handshake();
	endtask

	// Filtered overcurrent must cut the output and pull the line low.
	task automatic trip();
		@(posedge clk_sys);
		#2 sense.overcurrent_shutdown = 1'b1;
		wait_sig(0, 1'b0, FL * TK + 2 * TK);
		in_range("filter time", FL * TK - TK, FL * TK + TK);
		check("line low on fault", pin_level, 1'b0);
	endtask

	task automatic t_supply();
		for (int e = 0; e < 2; e++)
		begin
			@(posedge clk_sys);
			#2 supply_good = 1'b0;
			cfg.ext_supply = e[0];
			@(negedge clk_sys);
			check("line low in reset", pin_level, 1'b0);
			check("standby in reset", device_standby, 1'b0);
			@(posedge clk_sys);
			#2 supply_good = 1'b1;
			handshake();
		end
		ctrl.set_wake(1'b0);
		repeat (5 * TK) @(negedge clk_sys);
		check("wake pin ignored", device_standby, 1'b1);
		ctrl.set_wake(1'b1);
		cfg.ext_supply = 1'b0;
		$display("test supply done");
	endtask

	task automatic t_sleep();
		ctrl.set_wake(1'b0);
		repeat (3 * TK) @(negedge clk_sys);
		check("standby in sleep", device_standby, 1'b0);
		ctrl.set_wake(1'b1);
		wait_sig(1, 1'b0, 3 * TK);
		in_range("wake line low", 0, 2 * TK);
		handshake();
		$display("test sleep done");
	endtask

	task automatic t_latch();
		drive_enable = 1'b1;
		repeat (3) @(negedge clk_sys);
		check("enabled", output_enable, 1'b1);
		sense.ocp_hs_gnd = 1'b1;
		trip();
		check("status set", fault_status, 1'b1);
		check("sense clamp", sense_clamp_active, 1'b1);
		repeat ((RT + 5) * TK) @(negedge clk_sys);
		check("latched off", output_enable, 1'b0);
		ctrl.send_clear(1'b0);
		wait_sig(0, 1'b1, 4);
		in_range("reenable on clear", 0, 3);
		wait_sig(0, 1'b0, FL * TK + 2 * TK);
		in_range("retrip after clear", FL * TK - TK, FL * TK + TK);
		sense = '0;
		ctrl.send_clear(1'b0);
		repeat (3) @(negedge clk_sys);
		check("resume", output_enable, 1'b1);
		check("line high", pin_level, 1'b1);
		check("status cleared", fault_status, 1'b0);
		$display("test latch done");
	endtask

	task automatic t_retry();
		restart(1'b1, 1'b1);
		trip();
		wait_sig(0, 1'b1, RT * TK + 2 * TK);
		in_range("retry delay", RT * TK - TK, RT * TK + TK);
		check("line low on retry", pin_level, 1'b0);
		wait_sig(0, 1'b0, FL * TK + 2 * TK);
		in_range("retry retrip", FL * TK - TK, FL * TK + TK);
		sense.overcurrent_shutdown = 1'b0;
		wait_sig(0, 1'b1, RT * TK + 2 * TK);
		wait_sig(1, 1'b1, CL * TK + 3 * TK);
		in_range("clear time", CL * TK - TK, CL * TK + 2 * TK);
		check("kept on", output_enable, 1'b1);
		check("status held", fault_status, 1'b1);
		@(posedge clk_sys);
		#2 sense.thermal_shutdown_event = 1'b1;
		wait_sig(0, 1'b0, FL * TK + 2 * TK);
		repeat ((RT + 10) * TK) @(posedge clk_sys);
		#2 sense.thermal_shutdown_event = 1'b0;
		check("hot stays off", output_enable, 1'b0);
		wait_sig(0, 1'b1, CT * TK + 3 * TK);
		in_range("cool down", CT * TK - TK, CT * TK + 2 * TK);
		wait_sig(1, 1'b1, CL * TK + 3 * TK);
		in_range("hot clear time", CL * TK - TK, CL * TK + 2 * TK);
		ctrl.send_clear(1'b0);
		repeat (2) @(negedge clk_sys);
		check("status cleared", fault_status, 1'b0);
		$display("test retry done");
	endtask

	task automatic t_hard();
		restart(1'b0, 1'b0);
		trip();
		sense = '0;
		ctrl.pulse_wake();
		wait_sig(0, 1'b1, 4);
		in_range("pulse clears", 0, 3);
		$display("test hardwired done");
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Main sequence: serial internal supply, latch mode first.
	initial
	begin
		miscompares = 0;
		checks_done = 0;
		cycles = 0;
		rstn = 1'b0;
		supply_good = 1'b1;
		drive_enable = 1'b0;
		sense = '0;
		cfg = '0;
		restart(1'b0, 1'b1);
		t_supply();
		t_sleep();
		t_latch();
		t_retry();
		t_hard();
		end_of_test();
	end
endmodule

//--- verif/whf_ctrl_model.sv
// Controller-side model driving wake and fault-clear and reading the fault line.
`timescale 1ns/10ps
module whf_ctrl_model (
	input wire logic clk_sys,
	input wire logic pin_o,
	input wire logic pin_oe_n,
	output logic wake_request_pin,
	output logic fault_clear_command,
	output logic pin_level
);
	// The line has a pull-up, so it reads high whenever the device lets go.
	assign pin_level = pin_oe_n ? 1'b1 : pin_o;

	// Idle levels at time zero: awake, no command.
	initial
	begin
		wake_request_pin = 1'b1;
		fault_clear_command = 1'b0;
	end

	// Drive the wake level; high asks the device to leave sleep.
	task automatic set_wake(input logic v);
		@(posedge clk_sys);
		#2 wake_request_pin = v;
	endtask

	// One-cycle clear command; as an acknowledge it waits for the line to go low.
	task automatic send_clear(input bit need_low);
		int n;
		n = 0;
		while (need_low && pin_level !== 1'b0 && n < 1000)
		begin
			@(posedge clk_sys);
			n++;
		end
		@(posedge clk_sys);
		#2 fault_clear_command = 1'b1;
		@(posedge clk_sys);
		#2 fault_clear_command = 1'b0;
	endtask

	// Reset pulse on the wake pin, the hardwired acknowledge and clear.
	task automatic pulse_wake();
		set_wake(1'b0);
		@(posedge clk_sys);
		set_wake(1'b1);
	endtask
endmodule
